// ### verilog/sar_adc_params.svh
// Constants of the successive-approximation converter control block.
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

`define SAR_BITS             16
`define SAR_CLK_PERIOD_NS    5
// Period of the internal conversion clock in ns, one bit decision per period.
`define SAR_CONV_TICK_NS     20
`define SAR_CONV_TICK_CYCLES \
    ((`SAR_CONV_TICK_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_FIFO_DEPTH       8
`define SAR_CODE_ZERO        16'h0000
`define SAR_CODE_FULL        16'hffff
`define SAR_STATE_RESET      '0

`endif

// ### verilog/sar_adc_pkg.sv
// Types shared by the converter control block.
package sar_adc_pkg;

    // Conversion sequencer states.
    typedef enum logic [1:0]
    {
        ST_ACQ      = 2'b00,
        ST_OPEN_GND = 2'b01,
        ST_TRIAL    = 2'b10,
        ST_PUSH     = 2'b11
    } conv_state_t;

    // Pins from outside the clock domain, carried together through the synchroniser.
    typedef struct packed
    {
        logic under;
        logic over;
        logic cmp;
        logic sck;
        logic convert_strobe;
    } pins_t;

    // Analog switch controls; all zero is acquisition with the core powered down.
    typedef struct packed
    {
        logic pos_gnd_open;
        logic neg_gnd_open;
        logic arrays_to_ground;
        logic powered_up;
    } switches_t;

endpackage

// ### verilog/sar_adc_conversion_readout.sv
// Conversion sequencer, result FIFO and serial readout of a 16-bit SAR converter.
//
// Functional notes
// R1 - Rising convert_strobe ends acquisition and starts a conversion.
// R2 - Open both comparator ground switches first, then tie arrays to ground.
// R3 - Resolve 16 bits, MSB first, keep or clear each by comparator.
// R4 - After the last decision return to acquisition and present the code.
// R5 - Internal conversion clock sequences bits; shift clock is not needed.
// R6 - Power down between conversions.
// R7 - Delivered code belongs to the same conversion, no pipeline latency.
// R8 - Output code is straight binary; midscale is 8000.
// R9 - Over-range input gives FFFF.
// R10 - Under-range input gives 0000.
// R11 - Rising convert_strobe puts serial_result_out in high impedance.
// R12 - Falling convert_strobe drives the MSB onto serial_result_out.
// R13 - Each shift clock falling edge presents the next lower bit.
// R14 - Host may capture bits on either shift clock edge.
// R15 - Host keeps convert_strobe high for the longest conversion time.
// R16 - While convert_strobe is high, output stays off and result is unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_params.svh"

// ****************************************************************
// Result FIFO
// ****************************************************************
module sar_result_fifo #(
    parameter int unsigned WIDTH = `SAR_BITS,
    parameter int unsigned DEPTH = `SAR_FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed
    {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } fifo_state_t;

    fifo_state_t      st_q;
    fifo_state_t      st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             wr_en;
    logic             rd_en;

    // Pointer wrap; written out so that depths that are not a power of two work.
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Full and empty come straight from the occupancy count.
    assign o_in_ready  = (st_q.count != CW'(DEPTH));
    assign o_out_valid = (st_q.count != '0);
    assign o_out_data  = mem[st_q.rd_ptr];
    assign wr_en       = i_in_valid && o_in_ready;
    assign rd_en       = i_out_ready && o_out_valid;

    // Next pointers and count.
    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            st_d.wr_ptr = next_ptr(st_q.wr_ptr);
        end
        if (rd_en)
        begin
            st_d.rd_ptr = next_ptr(st_q.rd_ptr);
        end
        st_d.count = st_q.count + CW'(wr_en) - CW'(rd_en);
    end

    // Pointer state.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Storage has no reset; the count keeps stale words from being read.
    always_ff @(posedge i_clk)
    begin
        if (wr_en)
            mem[st_q.wr_ptr] <= i_in_data;
    end
endmodule

// ****************************************************************
// Converter control and serial readout
// ****************************************************************
module sar_adc_conversion_readout
    import sar_adc_pkg::*;
#(
    parameter int unsigned BITS        = `SAR_BITS,
    parameter int unsigned FIFO_DEPTH  = `SAR_FIFO_DEPTH,
    parameter int unsigned TICK_CYCLES = `SAR_CONV_TICK_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_convert_strobe,
    input  wire logic        i_shift_clk,
    input  wire logic        i_comparator,
    input  wire logic        i_over_range,
    input  wire logic        i_under_range,
    output logic             o_serial_result_out,
    output logic             o_serial_result_oe,
    output logic             o_pos_comparator_ground_switch_open,
    output logic             o_neg_comparator_ground_switch_open,
    output logic             o_arrays_to_ground,
    output logic             o_powered_up,
    output logic [BITS-1:0]  o_trial_code
);
    localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
    localparam int unsigned IW = $clog2(BITS);

    typedef struct packed
    {
        pins_t           sync1;
        pins_t           sync2;
        logic            cnv_prev;
        logic            sck_prev;
        conv_state_t     fsm;
        logic [CW-1:0]   tick_cnt;
        logic [IW-1:0]   bit_idx;
        logic [BITS-1:0] trial;
        logic            push_valid;
        logic [BITS-1:0] push_code;
        logic            reading;
        logic [BITS-1:0] shreg;
        logic [IW-1:0]   shift_cnt;
        logic            serial_result_out;
        logic            sdo_oe;
        switches_t       sw;
    } state_t;

    state_t          st_q;
    state_t          st_d;
    logic            tick;
    logic            cnv_rise;
    logic            cnv_fall;
    logic            sck_fall;
    logic            pop;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic [BITS-1:0] fifo_out_data;

    // Trial code with one more bit set.
    function automatic logic [BITS-1:0] set_bit(input logic [BITS-1:0] c, input logic [IW-1:0] i);
        set_bit    = c;
        set_bit[i] = 1'b1;
    endfunction

    // Range clamp; over-range wins should the front end flag both.
    function automatic logic [BITS-1:0] clamp_code(input logic [BITS-1:0] c, input logic ovr,
                                                   input logic und);
        clamp_code = ovr ? BITS'(`SAR_CODE_FULL) : (und ? BITS'(`SAR_CODE_ZERO) : c); // R9 R10
    endfunction

    // Edge detection reads only the second synchroniser stage.
    assign tick     = (st_q.tick_cnt == CW'(TICK_CYCLES - 1));
    assign cnv_rise = st_q.sync2.convert_strobe && !st_q.cnv_prev;
    assign cnv_fall = !st_q.sync2.convert_strobe && st_q.cnv_prev;
    assign sck_fall = !st_q.sync2.sck && st_q.sck_prev && !st_q.sync2.convert_strobe; // R16
    assign pop      = cnv_fall && fifo_out_valid;

    // Next state of sequencer and readout.
    always_comb
    begin
        logic [BITS-1:0] code;
        code              = st_q.trial;
        code[st_q.bit_idx] = st_q.sync2.cmp;                       // R3
        st_d              = st_q;
        st_d.sync1        = '{under: i_under_range, over: i_over_range, cmp: i_comparator,
                              sck: i_shift_clk, convert_strobe: i_convert_strobe};
        st_d.sync2        = st_q.sync1;
        st_d.cnv_prev     = st_q.sync2.convert_strobe;
        st_d.sck_prev     = st_q.sync2.sck;
        // The conversion clock is a divider of i_clk, so the shift clock never paces it.
        if (st_q.fsm != ST_ACQ)
        begin
            st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;        // R5
        end
        unique case (st_q.fsm)
            ST_ACQ:
            begin
                if (cnv_rise)                                         // R1
                begin
                    st_d.fsm             = ST_OPEN_GND;
                    st_d.tick_cnt        = '0;
                    st_d.sw.powered_up   = 1'b1;                      // R6
                    st_d.sw.pos_gnd_open = 1'b1;                      // R2
                    st_d.sw.neg_gnd_open = 1'b1;                      // R2
                end
            end
            ST_OPEN_GND:
            begin
                if (tick)
                begin
                    st_d.sw.arrays_to_ground = 1'b1;                  // R2
                    st_d.fsm                 = ST_TRIAL;
                    st_d.bit_idx             = IW'(BITS - 1);
                    st_d.trial               = set_bit('0, IW'(BITS - 1));  // R3
                end
            end
            ST_TRIAL:
            begin
                if (tick && st_q.bit_idx == '0)
                begin
                    st_d.trial      = code;
                    st_d.push_code  = clamp_code(code, st_q.sync2.over, st_q.sync2.under); // R8
                    st_d.push_valid = 1'b1;                           // R4
                    st_d.sw         = '0;                             // R6
                    st_d.fsm        = ST_PUSH;
                end
                else if (tick)
                begin
                    st_d.bit_idx = st_q.bit_idx - 1'b1;
                    st_d.trial   = set_bit(code, st_q.bit_idx - 1'b1); // R3
                end
            end
            ST_PUSH:
            begin
                // A full FIFO holds the code here and new convert edges are ignored.
                if (fifo_in_ready)
                begin
                    st_d.push_valid = 1'b0;
                    st_d.fsm        = ST_ACQ;
                end
            end
        endcase
        // Readout side.
        if (cnv_rise)
        begin
            st_d.sdo_oe  = 1'b0;                                      // R11
            st_d.reading = 1'b0;
        end
        else if (pop)
        begin
            st_d.shreg     = fifo_out_data;                           // R7
            st_d.serial_result_out       = fifo_out_data[BITS-1];                   // R12
            st_d.sdo_oe    = 1'b1;
            st_d.shift_cnt = '0;
            st_d.reading   = 1'b1;
        end
        else if (sck_fall && st_q.reading && st_q.shift_cnt != IW'(BITS - 1))
        begin
            st_d.shreg     = {st_q.shreg[BITS-2:0], 1'b0};            // R13
            st_d.serial_result_out       = st_q.shreg[BITS-2];                      // R13
            st_d.shift_cnt = st_q.shift_cnt + 1'b1;
        end
    end

    // All state in one register.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            st_q <= `SAR_STATE_RESET;
        else
            st_q <= st_d;
    end

    sar_result_fifo #(
        .WIDTH (BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (st_q.push_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (st_q.push_code),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_out_data)
    );

    // Outputs straight from state flops.
    assign o_serial_result_out                 = st_q.serial_result_out;
    assign o_serial_result_oe                  = st_q.sdo_oe;
    assign o_pos_comparator_ground_switch_open = st_q.sw.pos_gnd_open;
    assign o_neg_comparator_ground_switch_open = st_q.sw.neg_gnd_open;
    assign o_arrays_to_ground                  = st_q.sw.arrays_to_ground;
    assign o_powered_up                        = st_q.sw.powered_up;
    assign o_trial_code                        = st_q.trial;

    // ****************************************************************
    // Checks
    // ****************************************************************
    int unsigned conv_cycles;
    logic        last_dec;

    assign last_dec = (st_q.fsm == ST_TRIAL) && tick && (st_q.bit_idx == '0);

    // Counts the cycles of one conversion for the length check.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            conv_cycles <= 0;
        else if (st_q.fsm == ST_OPEN_GND || st_q.fsm == ST_TRIAL)
            conv_cycles <= conv_cycles + 1;
        else
            conv_cycles <= 0;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    cnv_starts_a: assert property (st_q.fsm == ST_ACQ && cnv_rise |=> st_q.fsm == ST_OPEN_GND
        && st_q.sw.powered_up && st_q.sw.pos_gnd_open && st_q.sw.neg_gnd_open) // R1
        else $error("Convert edge did not start a conversion.");
    gnd_order_a: assert property ($rose(st_q.sw.arrays_to_ground) |-> $past(st_q.sw.pos_gnd_open)
        && $past(st_q.sw.neg_gnd_open) && $past(st_q.fsm) == ST_OPEN_GND) // R2
        else $error("Arrays grounded before comparator switches opened.");
    msb_first_a: assert property ($rose(st_q.fsm == ST_TRIAL) |-> st_q.trial == set_bit('0,
        IW'(BITS - 1)) && st_q.bit_idx == IW'(BITS - 1)) // R3
        else $error("Conversion did not start with the MSB trial.");
    conv_len_a: assert property ($rose(st_q.fsm == ST_PUSH) |->
        conv_cycles == (BITS + 1) * TICK_CYCLES) // R5
        else $error("Conversion length wrong.");
    back_to_acq_a: assert property (last_dec |=> st_q.sw == '0 && st_q.push_valid) // R4
        else $error("No return to acquisition after last decision.");
    powered_down_a: assert property (st_q.fsm == ST_ACQ |-> !st_q.sw.powered_up) // R6
        else $error("Core powered while idle.");
    straight_code_a: assert property (last_dec && !st_q.sync2.over && !st_q.sync2.under
        |=> st_q.push_code == st_q.trial) // R8
        else $error("Code is not the resolved binary value.");
    clamp_over_a: assert property (last_dec && st_q.sync2.over
        |=> st_q.push_code == BITS'(`SAR_CODE_FULL)) // R9
        else $error("Over-range did not give all ones.");
    clamp_under_a: assert property (last_dec && st_q.sync2.under && !st_q.sync2.over
        |=> st_q.push_code == BITS'(`SAR_CODE_ZERO)) // R10
        else $error("Under-range did not give all zeros.");
    hiz_on_cnv_a: assert property (cnv_rise |=> !o_serial_result_oe) // R11
        else $error("Output still driven after convert edge.");
    msb_out_a: assert property (pop |=> o_serial_result_oe
        && o_serial_result_out == $past(fifo_out_data[BITS-1])
        && st_q.shreg == $past(fifo_out_data)) // R12
        else $error("MSB not presented on convert fall.");
    shift_out_a: assert property (sck_fall && st_q.reading && st_q.shift_cnt != IW'(BITS - 1)
        |=> o_serial_result_out == $past(st_q.shreg[BITS-2])) // R13
        else $error("Shift edge did not present next bit.");
    cnv_high_hold_a: assert property (st_q.sync2.convert_strobe && st_q.cnv_prev
        |=> $stable(st_q.shreg) && !o_serial_result_oe) // R16
        else $error("Result changed or driven while convert high.");

    full_conv_c: cover property (last_dec ##[1:20] st_q.fsm == ST_ACQ);
    full_read_c: cover property (st_q.reading && st_q.shift_cnt == IW'(BITS - 1));
    fifo_full_c: cover property (st_q.fsm == ST_PUSH && !fifo_in_ready);
endmodule

`default_nettype wire

// ### dv/sar_host_model.sv
// Host controller and analog front-end model facing the converter control block.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host and front-end model
// ****************************************************************
module sar_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_trial_code,
    input  wire logic        i_serial_result_out,
    input  wire logic        i_serial_result_oe,
    output logic             o_convert_strobe,
    output logic             o_shift_clk,
    output logic             o_comparator,
    output logic             o_over_range,
    output logic             o_under_range
);
    logic [15:0] target_q;
    logic        line;

    // A released result line shows the inverse of its last level, so stale data never matches.
    assign line = i_serial_result_oe ? i_serial_result_out : ~i_serial_result_out;

    // Idle levels at time zero; the shift clock stands still outside frames except while convert runs with shift_busy set.
    initial
    begin
        o_convert_strobe = 1'b0;
        o_shift_clk      = 1'b0;
        o_over_range     = 1'b0;
        o_under_range    = 1'b0;
        target_q         = 16'h0000;
    end

    // The comparator keeps a trial bit while the trial code does not exceed the held input.
    always @(negedge i_clk)
    begin
        o_comparator <= (i_trial_code <= target_q);
    end

    // Starts a conversion and holds the strobe for longer than the slowest conversion.
    task automatic convert(input logic [15:0] value, input logic over, input logic under,
                           input logic shift_busy);
        @(negedge i_clk);
        target_q         = value;
        o_over_range     = over;
        o_under_range    = under;
        o_convert_strobe = 1'b1;
        for (int n = 0; n < 90; n++)
        begin
            @(negedge i_clk);
            if (shift_busy && (n % 6 == 0))
                o_shift_clk = ~o_shift_clk;
        end
        o_shift_clk = 1'b0;
    endtask

    // Reads one frame; agree reports whether every bit held across both shift edges.
    task automatic read_frame(output logic [15:0] code, output logic agree);
        @(negedge i_clk);
        o_convert_strobe = 1'b0;
        agree = 1'b1;
        repeat (6) @(negedge i_clk);
        for (int i = 15; i >= 0; i--)
        begin
            #32 o_shift_clk = 1'b1;
            code[i] = line;
            #30 agree = agree & (line === code[i]);
            #2 o_shift_clk = 1'b0;
        end
        #32;
    endtask
endmodule
`default_nettype wire

// ### dv/sar_adc_conversion_readout_test.sv
// Self-checking testbench of the converter control and serial readout block.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_readout_test;
    logic        clk;
    logic        resetn;
    logic        cnv_pin;
    logic        shift;
    logic        cmp;
    logic        over;
    logic        under;
    logic        result_bit;
    logic        result_oe;
    logic        pos_open;
    logic        neg_open;
    logic        arrays_gnd;
    logic        powered;
    logic [15:0] trial;
    int          mismatches;
    int          cmp_count;

    // ****************************************************************
    // Design, partner and clock
    // ****************************************************************
    sar_adc_conversion_readout u_dut (
        .i_clk                               (clk),
        .i_resetn                            (resetn),
        .i_convert_strobe                    (cnv_pin),
        .i_shift_clk                         (shift),
        .i_comparator                        (cmp),
        .i_over_range                        (over),
        .i_under_range                       (under),
        .o_serial_result_out                 (result_bit),
        .o_serial_result_oe                  (result_oe),
        .o_pos_comparator_ground_switch_open (pos_open),
        .o_neg_comparator_ground_switch_open (neg_open),
        .o_arrays_to_ground                  (arrays_gnd),
        .o_powered_up                        (powered),
        .o_trial_code                        (trial)
    );

    sar_host_model u_host (
        .i_clk               (clk),
        .i_trial_code        (trial),
        .i_serial_result_out (result_bit),
        .i_serial_result_oe  (result_oe),
        .o_convert_strobe    (cnv_pin),
        .o_shift_clk         (shift),
        .o_comparator        (cmp),
        .o_over_range        (over),
        .o_under_range       (under)
    );

    // A 5 ns clock for the 200 MHz domain.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Follows one conversion at the switch pins; every wait is bounded.
    task automatic watch(input logic [15:0] target);
        int n;
        for (n = 0; n < 10 && powered !== 1'b1; n++) @(negedge clk);
        check("powered", {15'h0, powered}, 16'h0001);
        check("switch order", {13'h0, pos_open, neg_open, arrays_gnd}, 16'h0006);
        for (n = 0; n < 12 && arrays_gnd !== 1'b1; n++) @(negedge clk);
        check("switches open", {14'h0, pos_open, neg_open}, 16'h0003);
        check("first trial", trial, 16'h8000);
        for (n = 0; n < 8 && trial === 16'h8000; n++) @(negedge clk);
        check("second trial", trial, {target[15], 15'h4000});
        check("oe in conversion", {15'h0, result_oe}, 16'h0000);
        for (n = 0; n < 80 && powered !== 1'b0; n++) @(negedge clk);
        check("final trial", trial, target);
        check("switches idle", {13'h0, pos_open, neg_open, arrays_gnd}, 16'h0000);
    endtask

    // Converts one input and reads back the same conversion's frame.
    task automatic conv_read(input logic [15:0] target, input logic ov, input logic un,
                             input logic busy, output logic [15:0] code);
        logic agree;
        fork
            u_host.convert(target, ov, un, busy);
            watch(target);
        join
        check("powered down", {15'h0, powered}, 16'h0000);
        check("oe before read", {15'h0, result_oe}, 16'h0000);
        u_host.read_frame(code, agree);
        check("both edges", {15'h0, agree}, 16'h0001);
        check("oe after frame", {15'h0, result_oe}, 16'h0001);
    endtask

    // Codes around midscale and the ends of the range, each read right after its conversion.
    task automatic test_codes;
        logic [15:0] tab [7] = '{16'h8000, 16'h7fff, 16'h8001, 16'h0001, 16'h0000,
                                 16'hffff, 16'h5a3c};
        logic [15:0] code;
        foreach (tab[i])
        begin
            conv_read(tab[i], 1'b0, 1'b0, 1'b0, code);
            check("code", code, tab[i]);
        end
    endtask

    // Over-range clamps high, under-range clamps low, both together give all ones.
    task automatic test_clamps;
        logic [15:0] code;
        conv_read(16'h1234, 1'b1, 1'b0, 1'b0, code);
        check("over range", code, 16'hffff);
        conv_read(16'h1234, 1'b0, 1'b1, 1'b0, code);
        check("under range", code, 16'h0000);
        conv_read(16'h1234, 1'b1, 1'b1, 1'b0, code);
        check("both flags", code, 16'hffff);
    endtask

    // Shift clock edges during a conversion must not disturb it or the queued result.
    task automatic test_shift_in_conv;
        logic [15:0] code;
        conv_read(16'ha5c3, 1'b0, 1'b0, 1'b1, code);
        check("busy shift", code, 16'ha5c3);
        conv_read(16'h3c5a, 1'b0, 1'b0, 1'b1, code);
        check("next code", code, 16'h3c5a);
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    // Reset for 8 cycles, check idle outputs, then run every scenario.
    initial
    begin
        mismatches = 0;
        cmp_count  = 0;
        resetn     = 1'b0;
        repeat (8) @(negedge clk);
        check("reset outputs", {11'h0, result_oe, pos_open, neg_open, arrays_gnd, powered},
              16'h0000);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        test_codes();
        test_clamps();
        test_shift_in_conv();
        results();
    end

    // Twelve conversions take about 20 us; the margin allows a slow but working design.
    initial
    begin
        #100000;
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
